// File: rtl/tss_top.sv
module tss_top
  import tss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic termination_control_pin,
  input wire logic wr_cmd,
  input wire logic rd_cmd,
  input wire logic burst_chop,
  input wire logic self_refresh,
  input wire logic [2:0] mode_register_one_nom,
  input wire logic [1:0] mode_register_two_wr,
  input wire logic [2:0] mode_register_five_park,
  input wire logic preamble_2t,
  input wire logic write_crc_en,
  input wire logic [TSS_LAT_W-1:0] read_latency_cycles,
  input wire logic [TSS_LAT_W-1:0] write_latency_cycles,
  input wire logic cfg_x8,
  input wire logic tdqs_en,
  output tss_pkg::tss_state_t term_state,
  output logic [2:0] rtt_code,
  output logic odt_rx_en,
  output logic term_data_en,
  output logic term_strobe_pair_en,
  output logic term_enabled
);
  import tss_pkg::*;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic nom_en;
  logic wr_en;
  logic park_en;
  logic [TSS_LAT_W-1:0] x_off;
  logic [TSS_LAT_W-1:0] y_ext;
  logic [TSS_LAT_W-1:0] half_bl;
  logic [TSS_LAT_W-1:0] rd_delay;
  logic [TSS_LAT_W-1:0] rd_len;
  logic [TSS_LAT_W-1:0] wr_delay;
  logic [TSS_LAT_W-1:0] wr_len;
  logic [TSS_LAT_W-1:0] nom_delay;
  logic rd_active;
  logic wr_active;
  logic pin_q;
  logic nom_on;
  logic [TSS_HIST_DEPTH-1:0] pin_hist_r;
  tss_state_t state_nxt;
  logic [2:0] rtt_nxt;

  // Field decode; any non-zero field enables termination.
  assign nom_en = (mode_register_one_nom != TSS_RTT_OFF);
  assign wr_en = (mode_register_two_wr != TSS_WR_OFF);
  assign park_en = (mode_register_five_park != TSS_RTT_OFF); // see RULE_02

  // Window offsets follow preamble and CRC modes.
  assign x_off = preamble_2t ? TSS_X_PRE2 : TSS_X_PRE1; // see RULE_08
  assign y_ext = write_crc_en ? TSS_Y_CRC : '0; // see RULE_09
  assign half_bl = burst_chop ? TSS_HALF_BC4 : TSS_HALF_BL8; // see RULE_18

  // Read window starts RL-X after command and lasts BL/2+X+Y cycles.
  assign rd_delay = (read_latency_cycles > x_off) ? read_latency_cycles - x_off : '0; // see RULE_07
  assign rd_len = half_bl + x_off + y_ext; // see RULE_07

  // Write window starts WL-2 after command, length by burst and CRC.
  assign wr_delay = (write_latency_cycles > TSS_WR_LAT_SUB) ? write_latency_cycles - TSS_WR_LAT_SUB : '0;
  assign wr_len = (burst_chop ? TSS_WR_LEN_BC4 : TSS_WR_LEN_BL8) + y_ext; // see RULE_18
  assign nom_delay = (write_latency_cycles > TSS_NOM_LAT_SUB) ? write_latency_cycles - TSS_NOM_LAT_SUB : '0;

  // ----------------------------------------------------------------
  // Command windows
  // ----------------------------------------------------------------
  tss_window u_rd_win
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .trig(rd_cmd && !self_refresh),
    .delay(rd_delay),
    .len(rd_len),
    .active(rd_active)
  );

  tss_window u_wr_win
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .trig(wr_cmd && wr_en && !self_refresh),
    .delay(wr_delay),
    .len(wr_len),
    .active(wr_active)
  );

  // ----------------------------------------------------------------
  // Pin sampling and nominal latency
  // ----------------------------------------------------------------
  // The pin is masked when nominal is off or in self-refresh.
  assign pin_q = termination_control_pin && nom_en && !self_refresh; // see RULE_16

  // Shift history of pin samples so nominal follows WL-2 later.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pin_hist_r <= '0;
    else
      pin_hist_r <= {pin_hist_r[TSS_HIST_DEPTH-2:0], pin_q}; // see RULE_17
  end

  // Zero latency uses the live sample.
  assign nom_on = (nom_delay == '0) ? pin_q : pin_hist_r[nom_delay - 6'h01]; // see RULE_05

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  // Disable beats write, write beats nominal, nominal beats park.
  always_comb
  begin
    state_nxt = TSS_HIZ;
    rtt_nxt = TSS_RTT_OFF;
    if (self_refresh)
    begin
      state_nxt = TSS_HIZ; // see RULE_03
      rtt_nxt = TSS_RTT_OFF;
    end
    else if (rd_active)
    begin
      state_nxt = TSS_HIZ; // see RULE_10, RULE_12
      rtt_nxt = TSS_RTT_OFF;
    end
    else if (wr_active)
    begin
      state_nxt = TSS_WR; // see RULE_04, RULE_11
      rtt_nxt = {1'b0, mode_register_two_wr};
    end
    else if (nom_on)
    begin
      state_nxt = TSS_NOM; // see RULE_05
      rtt_nxt = mode_register_one_nom; // see RULE_15
    end
    else if (park_en)
    begin
      state_nxt = TSS_PARK; // see RULE_06
      rtt_nxt = mode_register_five_park;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // State register holds exactly one of four codes.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      term_state <= TSS_HIZ; // see RULE_01
      rtt_code <= TSS_RTT_OFF;
    end
    else
    begin
      term_state <= state_nxt; // see RULE_01
      rtt_code <= rtt_nxt;
    end
  end

  // Pin enables and receiver power.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      odt_rx_en <= 1'b0;
      term_data_en <= 1'b0;
      term_strobe_pair_en <= 1'b0;
      term_enabled <= 1'b0;
    end
    else
    begin
      odt_rx_en <= nom_en && !self_refresh; // see RULE_13
      term_data_en <= (rtt_nxt != TSS_RTT_OFF); // see RULE_14
      term_strobe_pair_en <= (rtt_nxt != TSS_RTT_OFF) && cfg_x8 && tdqs_en; // see RULE_14
      term_enabled <= nom_en || wr_en || park_en; // see RULE_02
    end
  end

endmodule

// File: inc/tss_pkg.sv
// Contract
// RULE_01 - Exactly one of four termination states held
// RULE_02 - Termination enabled when any field non-zero
// RULE_03 - Self-refresh forces termination off, Hi-Z
// RULE_04 - Write applies write termination regardless of pin
// RULE_05 - Asserted pin turns nominal on if enabled
// RULE_06 - Park enabled and pin low gives park
// RULE_07 - Read disables termination RL-X for BL/2+X+Y
// RULE_08 - X is 2 or 3 by preamble
// RULE_09 - Y is 0 or 1 by write CRC
// RULE_10 - Priority: disable, write, nominal, park
// RULE_11 - Write with pin high gives write termination
// RULE_12 - Read ignores pin and nominal/park settings
// RULE_13 - Nominal disabled: pin ignored, receiver powered down
// RULE_14 - Termination on data, mask, strobe; pair x8 only
// RULE_15 - Fields select 240 down to 34 ohms
// RULE_16 - Pin ignored when nominal zero or self-refresh
// RULE_17 - Nominal follows pin after write latency minus two
// RULE_18 - Latency and burst from current programmed values
package tss_pkg;

  // ----------------------------------------------------------------
  // Termination states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    TSS_HIZ = 2'b00,
    TSS_WR = 2'b01,
    TSS_NOM = 2'b10,
    TSS_PARK = 2'b11
  } tss_state_t;

  // ----------------------------------------------------------------
  // Widths and timing constants
  // ----------------------------------------------------------------
  localparam int TSS_LAT_W = 6;
  localparam int TSS_CNT_W = 7;
  localparam logic [2:0] TSS_RTT_OFF = 3'h0;
  localparam logic [1:0] TSS_WR_OFF = 2'h0;
  localparam logic [TSS_LAT_W-1:0] TSS_X_PRE1 = 6'h02;
  localparam logic [TSS_LAT_W-1:0] TSS_X_PRE2 = 6'h03;
  localparam logic [TSS_LAT_W-1:0] TSS_Y_CRC = 6'h01;
  localparam logic [TSS_LAT_W-1:0] TSS_NOM_LAT_SUB = 6'h02;
  localparam logic [TSS_LAT_W-1:0] TSS_WR_LAT_SUB = 6'h02;
  localparam logic [TSS_LAT_W-1:0] TSS_WR_LEN_BL8 = 6'h06;
  localparam logic [TSS_LAT_W-1:0] TSS_WR_LEN_BC4 = 6'h04;
  localparam logic [TSS_LAT_W-1:0] TSS_HALF_BL8 = 6'h04;
  localparam logic [TSS_LAT_W-1:0] TSS_HALF_BC4 = 6'h02;
  localparam logic [6:0] TSS_HIST_DEPTH = 7'h40;
  localparam logic TSS_RST_SR = 1'b0;

endpackage

// File: rtl/tss_window.sv
// Delayed-window timer: opens DELAY cycles after a trigger, stays LEN cycles.
module tss_window
  import tss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic trig,
  input wire logic [TSS_LAT_W-1:0] delay,
  input wire logic [TSS_LAT_W-1:0] len,
  output logic active
);

  logic [TSS_CNT_W-1:0] start_cnt_r;
  logic [TSS_CNT_W-1:0] run_cnt_r;
  logic pend_r;

  // A new trigger restarts the delay; a start still pending is dropped.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pend_r <= 1'b0;
      start_cnt_r <= '0;
    end
    else if (trig)
    begin
      pend_r <= (delay > 6'h01);
      start_cnt_r <= {1'b0, delay} - 7'h01;
    end
    else if (pend_r)
    begin
      start_cnt_r <= start_cnt_r - 7'h01;
      pend_r <= (start_cnt_r > 7'h01);
    end
  end

  // Window run counter loads when the delay expires.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      run_cnt_r <= '0;
    else if ((trig && delay <= 6'h01) || (pend_r && start_cnt_r <= 7'h01 && !trig))
      run_cnt_r <= {1'b0, len};
    else if (run_cnt_r != '0)
      run_cnt_r <= run_cnt_r - 7'h01;
  end

  assign active = (run_cnt_r != '0);

endmodule

// File: tb/tss_checker.sv
// ----
// Port checks
// ----
module tss_checker
  import tss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr_cmd,
  input wire logic rd_cmd,
  input wire logic self_refresh,
  input wire logic [2:0] mode_register_one_nom,
  input wire logic [1:0] mode_register_two_wr,
  input wire logic [2:0] mode_register_five_park,
  input wire logic preamble_2t,
  input wire logic [TSS_LAT_W-1:0] read_latency_cycles,
  input wire logic [TSS_LAT_W-1:0] write_latency_cycles,
  input wire logic cfg_x8,
  input wire logic tdqs_en,
  input wire tss_pkg::tss_state_t term_state,
  input wire logic [2:0] rtt_code,
  input wire logic odt_rx_en,
  input wire logic term_strobe_pair_en,
  input wire logic term_enabled
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_hiz_code_zero: assert property (term_state == TSS_HIZ |-> rtt_code == 3'h0) else $error("code in hiz");
  chk_nom_code_match: assert property (
    term_state == TSS_NOM |-> rtt_code == $past(mode_register_one_nom)) else $error("nominal code");
  chk_refresh_forces_hiz: assert property (
    self_refresh [*2] |-> term_state == TSS_HIZ && !odt_rx_en) else $error("refresh not hiz");
  chk_read_window_hiz: assert property (
    rd_cmd && !self_refresh && !preamble_2t && read_latency_cycles == 6'h06
    |-> ##6 (term_state == TSS_HIZ) [*3]) else $error("read window");
  chk_write_window_sel: assert property (
    wr_cmd && mode_register_two_wr != 2'h0 && !self_refresh &&
    write_latency_cycles == 6'h06 |-> ##6 (term_state == TSS_WR) [*3]) else $error("write window");
  chk_pair_x8_only: assert property (
    (!cfg_x8 || !tdqs_en) [*2] |-> !term_strobe_pair_en) else $error("pair on");
  chk_pin_rx_power: assert property (
    $past(rst_n) |-> odt_rx_en == ($past(mode_register_one_nom) != 3'h0 &&
    !$past(self_refresh))) else $error("rx enable");
  chk_any_field_en: assert property (
    $past(rst_n) |-> term_enabled == (|{$past(mode_register_one_nom),
    $past(mode_register_two_wr), $past(mode_register_five_park)})) else $error("enabled");
endmodule

bind tss_top tss_checker i_chk (.*);

// File: tb/tss_ctrl_model.sv
// Controller side: commands as one-cycle pulses launched at falling edges.
module tss_ctrl_model
(
  input wire logic core_clk,
  output logic termination_control_pin,
  output logic wr_cmd,
  output logic rd_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {termination_control_pin, wr_cmd, rd_cmd} = 3'h0;
  // Returns at the falling edge just after the command was sampled.
  task automatic send(input logic rd, input logic wr);
    @(negedge core_clk);
    rd_cmd = rd;
    wr_cmd = wr;
    @(negedge core_clk);
    rd_cmd = 1'b0;
    wr_cmd = 1'b0;
  endtask
endmodule

// File: tb/termination_state_select_test.sv
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module termination_state_select_test;
  import tss_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst_n = 0, termination_control_pin, wr_cmd, rd_cmd, burst_chop, self_refresh;
  logic [2:0] mode_register_one_nom, mode_register_five_park, rtt_code;
  logic [1:0] mode_register_two_wr;
  logic preamble_2t, write_crc_en, cfg_x8, tdqs_en, odt_rx_en, term_data_en, term_strobe_pair_en, term_enabled;
  logic [TSS_LAT_W-1:0] read_latency_cycles, write_latency_cycles;
  tss_state_t term_state;
  int n_errors = 0, tests_run = 0, seed = 64, cyc = 0, i, k, st, ln;
  tss_top i_dut (.*);
  tss_ctrl_model i_ctl (.core_clk(core_clk), .termination_control_pin(termination_control_pin),
    .wr_cmd(wr_cmd), .rd_cmd(rd_cmd));
  always #25 core_clk = ~core_clk;
  // Stops a hung run.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Expected disable window start and length after a read.
  function automatic int exp_start(input int rl, input logic pre);
    return (rl - (pre ? 3 : 2)) < 1 ? 1 : rl - (pre ? 3 : 2);
  endfunction
  function automatic int exp_len(input logic pre, input logic crc, input logic chop);
    return (chop ? 2 : 4) + (pre ? 3 : 2) + crc;
  endfunction
  // ----
  // Main sequence
  // ----
  initial
  begin
    {burst_chop, self_refresh, preamble_2t, write_crc_en, cfg_x8, tdqs_en} = 6'h00;
    {mode_register_one_nom, mode_register_two_wr, mode_register_five_park} = 8'h00;
    read_latency_cycles = 6'h06;
    write_latency_cycles = 6'h06;
    settle(12);
    rst_n = 1'b1;
    settle(2);
    `CHK("state", TSS_HIZ, term_state)
    `CHK("enabled", 1'b0, term_enabled)
    for (i = 0; i < 4; i++)
    begin
      mode_register_five_park = 3'($random(seed)) | 3'h1;
      mode_register_one_nom = i[0] ? (3'($random(seed)) | 3'h1) : 3'h0;
      {cfg_x8, tdqs_en} = i[1:0];
      i_ctl.termination_control_pin = 1'b1;
      settle(10);
      `CHK("state", i[0] ? TSS_NOM : TSS_PARK, term_state)
      `CHK("code", i[0] ? mode_register_one_nom : mode_register_five_park, rtt_code)
      `CHK("rx", i[0], odt_rx_en)
      `CHK("pair", cfg_x8 & tdqs_en, term_strobe_pair_en)
      `CHK("data", 1'b1, term_data_en)
      i_ctl.termination_control_pin = 1'b0;
      settle(10);
      `CHK("state", TSS_PARK, term_state)
    end
    $display("test park and nominal done");
    mode_register_two_wr = 2'($random(seed)) | 2'h1;
    for (i = 0; i < 2; i++)
    begin
      i_ctl.termination_control_pin = i[0];
      settle(10);
      i_ctl.send(1'b0, 1'b1);
      settle(5);
      `CHK("state", TSS_WR, term_state)
    end
    $display("test write done");
    i_ctl.termination_control_pin = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      {preamble_2t, write_crc_en, burst_chop} = 3'(i);
      read_latency_cycles = (i < 4) ? 6'h06 : 6'(5 + $unsigned($random(seed)) % 4);
      settle(12);
      i_ctl.send(1'b1, 1'b0);
      st = 0;
      ln = 0;
      for (k = 1; k <= 20; k++)
      begin
        settle(1);
        if (term_state === TSS_HIZ)
        begin
          if (ln == 0)
            st = k;
          ln++;
        end
      end
      `CHK("start", exp_start(read_latency_cycles, preamble_2t), st)
      `CHK("length", exp_len(preamble_2t, write_crc_en, burst_chop), ln)
    end
    $display("test read done");
    self_refresh = 1'b1;
    settle(3);
    i_ctl.send(1'b1, 1'b1);
    settle(8);
    `CHK("state", TSS_HIZ, term_state)
    `CHK("rx", 1'b0, odt_rx_en)
    `CHK("data", 1'b0, term_data_en)
    self_refresh = 1'b0;
    settle(10);
    `CHK("state", TSS_NOM, term_state)
    $display("test self refresh done");
    complete_run();
  end
endmodule
